// ### src/prs_params.svh
// Constants for the power, reset and security housekeeping block
`ifndef PRS_PARAMS_SVH
`define PRS_PARAMS_SVH
`define PRS_NUM_REGS 10
`define PRS_NUM_INPUTS 12
`define PRS_SIG_BITS 64
`define PRS_SIG_BYTES 8
`define PRS_SIG_ADDR_W 3
`define PRS_CLK_PERIOD_NS 40
`define PRS_CLEAR_INTERVAL_NS 1000
`define PRS_CLEAR_CYCLES ((`PRS_CLEAR_INTERVAL_NS + `PRS_CLK_PERIOD_NS - 1) / `PRS_CLK_PERIOD_NS)
`define PRS_CNT_W 6
`endif

// ### src/prs_pkg.sv
// Types for the power, reset and security housekeeping block
package prs_pkg;
  typedef enum logic [1:0] {
    PRS_CLEARING,
    PRS_RUN,
    PRS_SLEEP
  } prs_state_t;
endpackage

// ### src/prs_sig_mem.sv
// Signature byte memory with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "prs_params.svh"
module prs_sig_mem (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [`PRS_SIG_ADDR_W-1:0] addr_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] rd_data_out
);
  logic [7:0] mem_q [`PRS_SIG_BYTES];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < `PRS_SIG_BYTES; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else if (wr_en_in) begin
      mem_q[addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= mem_q[addr_in];
    end
  end
endmodule
`default_nettype wire

// ### src/prs_top.sv
// Power-up clear, preload, signature, security and sleep control
`timescale 1ns/1ps
`default_nettype none
`include "prs_params.svh"
module prs_top
  import prs_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [`PRS_NUM_INPUTS-1:0] LOGIC_IN,
  input wire logic [`PRS_NUM_REGS-1:0] IO_IN,
  input wire logic [`PRS_NUM_REGS-1:0] IO_DRIVEN_IN,
  input wire logic INPUT_OR_SLEEP_PIN_IN,
  input wire logic SLEEP_ENABLE_FUSE_IN,
  input wire logic [`PRS_NUM_REGS-1:0] NEXT_STATE_IN,
  input wire logic [`PRS_NUM_REGS-1:0] REG_CAPTURE_IN,
  input wire logic SYNC_RESET_TERM_IN,
  input wire logic ASYNC_RESET_TERM_IN,
  input wire logic [`PRS_NUM_REGS-1:0] OUT_POLARITY_IN,
  input wire logic [`PRS_NUM_REGS-1:0] OUT_ENABLE_IN,
  input wire logic PRELOAD_EN_IN,
  input wire logic [3:0] PRELOAD_SEL_IN,
  input wire logic PRELOAD_VALUE_IN,
  input wire logic VERIFY_REQ_IN,
  input wire logic [7:0] VERIFY_DATA_IN,
  input wire logic SECURE_PROGRAM_IN,
  input wire logic SIG_WR_IN,
  input wire logic [`PRS_SIG_ADDR_W-1:0] SIG_ADDR_IN,
  input wire logic [7:0] SIG_WR_DATA_IN,
  output logic [7:0] SIG_RD_DATA_OUT,
  output logic [`PRS_NUM_REGS-1:0] IO_OUT,
  output logic [`PRS_NUM_REGS-1:0] IO_OE_OUT,
  output logic [`PRS_NUM_INPUTS-1:0] ARRAY_IN_OUT,
  output logic [`PRS_NUM_REGS-1:0] ARRAY_FB_OUT,
  output logic [`PRS_NUM_REGS-1:0] REG_STATE_OUT,
  output logic SYNC_RESET_TERM_OUT,
  output logic ASYNC_RESET_TERM_OUT,
  output logic [7:0] VERIFY_DATA_OUT,
  output logic VERIFY_VALID_OUT,
  output logic SECURED_OUT,
  output logic CLEAR_DONE_OUT,
  output logic SLEEPING_OUT
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  prs_state_t state_q;
  logic [`PRS_CNT_W-1:0] clr_cnt_q;
  logic sleep_req;
  logic run_ok;

  assign sleep_req = SLEEP_ENABLE_FUSE_IN && INPUT_OR_SLEEP_PIN_IN;
  assign run_ok = (state_q == PRS_RUN) && !sleep_req;

  always_ff @(posedge CORE_CLK_IN or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= PRS_CLEARING;
      clr_cnt_q <= '0;
    end else begin
      case (state_q)
        PRS_CLEARING: begin
          // Clear stays active for the whole interval
          if (clr_cnt_q == `PRS_CNT_W'(`PRS_CLEAR_CYCLES - 1)) begin
            state_q <= PRS_RUN;
          end else begin
            clr_cnt_q <= clr_cnt_q + `PRS_CNT_W'(1);
          end
        end
        PRS_RUN: begin
          if (sleep_req) begin
            state_q <= PRS_SLEEP;
          end
        end
        PRS_SLEEP: begin
          if (!sleep_req) begin
            state_q <= PRS_RUN;
          end
        end
        default: begin
          state_q <= PRS_CLEARING;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      CLEAR_DONE_OUT <= 1'b0;
      SLEEPING_OUT <= 1'b0;
    end else begin
      CLEAR_DONE_OUT <= (state_q != PRS_CLEARING);
      SLEEPING_OUT <= (state_q == PRS_SLEEP) || (state_q == PRS_RUN && sleep_req);
    end
  end

  // ----------------------------------------------------------------
  // Security fuse
  // ----------------------------------------------------------------
  logic secured_q;
  logic secure_now;

  assign secure_now = secured_q || SECURE_PROGRAM_IN;

  always_ff @(posedge CORE_CLK_IN or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      secured_q <= 1'b0;
    end else if (SECURE_PROGRAM_IN) begin
      secured_q <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      SECURED_OUT <= 1'b0;
    end else begin
      SECURED_OUT <= secure_now;
    end
  end

  // ----------------------------------------------------------------
  // Macrocell registers and preload
  // ----------------------------------------------------------------
  logic [`PRS_NUM_REGS-1:0] regs_q;
  logic sreset_q;
  logic areset_q;
  logic preload_ok;

  assign preload_ok = PRELOAD_EN_IN && !secure_now && (state_q == PRS_RUN) &&
                      (PRELOAD_SEL_IN < 4'(`PRS_NUM_REGS));

  always_ff @(posedge CORE_CLK_IN or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sreset_q <= 1'b0;
      areset_q <= 1'b0;
    end else if (run_ok) begin
      sreset_q <= SYNC_RESET_TERM_IN;
      areset_q <= ASYNC_RESET_TERM_IN;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      regs_q <= '0;
    end else if (state_q == PRS_CLEARING) begin
      regs_q <= '0;
    end else if (preload_ok && !sleep_req) begin
      regs_q[PRELOAD_SEL_IN] <= PRELOAD_VALUE_IN;
    end else if (run_ok) begin
      // Sleep freezes state; clock and data ignored
      if (areset_q || sreset_q) begin
        regs_q <= '0;
      end else begin
        for (int i = 0; i < `PRS_NUM_REGS; i++) begin
          if (REG_CAPTURE_IN[i]) begin
            regs_q[i] <= NEXT_STATE_IN[i];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin keepers and array inputs
  // ----------------------------------------------------------------
  logic [`PRS_NUM_REGS-1:0] io_keep_q;

  always_ff @(posedge CORE_CLK_IN or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      io_keep_q <= '0;
    end else if (!sleep_req) begin
      for (int i = 0; i < `PRS_NUM_REGS; i++) begin
        if (IO_DRIVEN_IN[i]) begin
          io_keep_q[i] <= IO_IN[i];
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ARRAY_IN_OUT <= '0;
      ARRAY_FB_OUT <= '0;
    end else if (!sleep_req) begin
      // Held values cover undriven pins sleep freezes these
      ARRAY_IN_OUT <= LOGIC_IN;
      if (SLEEP_ENABLE_FUSE_IN) begin
        ARRAY_IN_OUT[0] <= 1'b0;
      end else begin
        ARRAY_IN_OUT[0] <= INPUT_OR_SLEEP_PIN_IN;
      end
      for (int i = 0; i < `PRS_NUM_REGS; i++) begin
        ARRAY_FB_OUT[i] <= IO_DRIVEN_IN[i] ? IO_IN[i] : io_keep_q[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      IO_OUT <= '0;
      IO_OE_OUT <= '0;
      REG_STATE_OUT <= '0;
      SYNC_RESET_TERM_OUT <= 1'b0;
      ASYNC_RESET_TERM_OUT <= 1'b0;
    end else if (!sleep_req) begin
      // Sleep holds every pin as it stood, whatever its state
      IO_OUT <= regs_q ^ OUT_POLARITY_IN;
      IO_OE_OUT <= OUT_ENABLE_IN;
      REG_STATE_OUT <= regs_q;
      SYNC_RESET_TERM_OUT <= sreset_q;
      ASYNC_RESET_TERM_OUT <= areset_q;
    end
  end

  // ----------------------------------------------------------------
  // Fuse verify
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      VERIFY_DATA_OUT <= 8'h00;
      VERIFY_VALID_OUT <= 1'b0;
    end else begin
      VERIFY_VALID_OUT <= VERIFY_REQ_IN && !secure_now;
      VERIFY_DATA_OUT <= (VERIFY_REQ_IN && !secure_now) ? VERIFY_DATA_IN : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Signature storage
  // ----------------------------------------------------------------
  prs_sig_mem u_sig (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(rst_sync_q),
    .wr_en_in(SIG_WR_IN),
    .addr_in(SIG_ADDR_IN),
    .wr_data_in(SIG_WR_DATA_IN),
    .rd_data_out(SIG_RD_DATA_OUT)
  );
endmodule
`default_nettype wire

// ### testbench/prs_sva.sv
// Port checks for the housekeeping block
`timescale 1ns/1ps
`default_nettype none
module prs_sva (
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic SLEEP_ENABLE_FUSE_IN,
  input wire logic INPUT_OR_SLEEP_PIN_IN,
  input wire logic VERIFY_REQ_IN,
  input wire logic SECURE_PROGRAM_IN,
  input wire logic [7:0] VERIFY_DATA_IN,
  input wire logic [9:0] OUT_POLARITY_IN,
  input wire logic [9:0] IO_OUT,
  input wire logic [9:0] REG_STATE_OUT,
  input wire logic [11:0] ARRAY_IN_OUT,
  input wire logic [7:0] VERIFY_DATA_OUT,
  input wire logic VERIFY_VALID_OUT,
  input wire logic SECURED_OUT,
  input wire logic CLEAR_DONE_OUT,
  input wire logic SYNC_RESET_TERM_OUT,
  input wire logic ASYNC_RESET_TERM_OUT
);
  wire slp = SLEEP_ENABLE_FUSE_IN && INPUT_OR_SLEEP_PIN_IN;
  wire go = CLEAR_DONE_OUT && !slp;
  logic [5:0] cnt_q;
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cnt_q <= 6'h00;
    end else if (cnt_q != 6'h3f) begin
      cnt_q <= cnt_q + 6'h01;
    end
  end
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  a_clear_regs: assert property (!CLEAR_DONE_OUT |-> REG_STATE_OUT == 10'h000)
    else $error("register set during clear");
  a_clear_len: assert property ($rose(CLEAR_DONE_OUT) |-> cnt_q >= 6'h19 && cnt_q <= 6'h1f)
    else $error("clear phase length wrong");
  a_clear_bound: assert property (cnt_q == 6'h22 |-> CLEAR_DONE_OUT)
    else $error("clear phase never ended");
  a_out_polarity: assert property ($past(go) |-> IO_OUT == (REG_STATE_OUT ^ $past(OUT_POLARITY_IN)))
    else $error("pin level not register through polarity");
  a_verify_block: assert property (SECURED_OUT |-> !VERIFY_VALID_OUT)
    else $error("verify answered while secured");
  a_verify_pass: assert property (go && VERIFY_REQ_IN && !SECURED_OUT && !SECURE_PROGRAM_IN
    |=> VERIFY_VALID_OUT && VERIFY_DATA_OUT == $past(VERIFY_DATA_IN))
    else $error("verify not answered");
  a_secure_sticky: assert property ((go && SECURE_PROGRAM_IN) || SECURED_OUT |=> SECURED_OUT)
    else $error("secure flag lost");
  a_sleep_freeze: assert property (CLEAR_DONE_OUT && slp
    |=> $stable(REG_STATE_OUT) && $stable(IO_OUT) && $stable(ARRAY_IN_OUT))
    else $error("state moved in sleep");
  a_dual_pin: assert property (go |=> ARRAY_IN_OUT[0]
    == ($past(INPUT_OR_SLEEP_PIN_IN) && !$past(SLEEP_ENABLE_FUSE_IN)))
    else $error("dual pin array input wrong");
  a_terms_clear: assert property (!CLEAR_DONE_OUT |-> !SYNC_RESET_TERM_OUT && !ASYNC_RESET_TERM_OUT)
    else $error("reset term set during clear");
endmodule
bind prs_top prs_sva u_sva (.CORE_CLK_IN, .RST_N_IN, .SLEEP_ENABLE_FUSE_IN, .INPUT_OR_SLEEP_PIN_IN,
  .VERIFY_REQ_IN, .SECURE_PROGRAM_IN, .VERIFY_DATA_IN, .OUT_POLARITY_IN, .IO_OUT, .REG_STATE_OUT,
  .ARRAY_IN_OUT, .VERIFY_DATA_OUT, .VERIFY_VALID_OUT, .SECURED_OUT, .CLEAR_DONE_OUT,
  .SYNC_RESET_TERM_OUT, .ASYNC_RESET_TERM_OUT);
`default_nettype wire

// ### testbench/prs_far_side.sv
// Far-side system logic: capture events and pin drivers
`timescale 1ns/1ps
`default_nettype none
module prs_far_side (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clear_done_in,
  input wire logic [9:0] cap_req_in,
  input wire logic [9:0] drive_req_in,
  input wire logic [9:0] io_val_in,
  output logic [9:0] capture_out,
  output logic [9:0] io_out,
  output logic [9:0] io_driven_out
);
  logic settled_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      settled_q <= 1'b0;
      io_out <= 10'h000;
    end else begin
      settled_q <= clear_done_in;
      io_out <= (io_val_in & drive_req_in) | (~io_out & ~drive_req_in);
    end
  end
  // No capture events until clear is over and inputs settled
  assign capture_out = settled_q ? cap_req_in : 10'h000;
  assign io_driven_out = drive_req_in;
endmodule
`default_nettype wire

// ### testbench/prs_top_tb.sv
// Self-checking bench for the housekeeping block
`timescale 1ns/1ps
`default_nettype none
module prs_top_tb;
  logic CORE_CLK_IN, RST_N_IN, INPUT_OR_SLEEP_PIN_IN, SLEEP_ENABLE_FUSE_IN;
  logic SYNC_RESET_TERM_IN, ASYNC_RESET_TERM_IN, PRELOAD_EN_IN, PRELOAD_VALUE_IN;
  logic VERIFY_REQ_IN, SECURE_PROGRAM_IN, SIG_WR_IN, VERIFY_VALID_OUT, SECURED_OUT;
  logic CLEAR_DONE_OUT, SLEEPING_OUT, SYNC_RESET_TERM_OUT, ASYNC_RESET_TERM_OUT;
  logic [11:0] LOGIC_IN, ARRAY_IN_OUT;
  logic [9:0] IO_IN, IO_DRIVEN_IN, NEXT_STATE_IN, REG_CAPTURE_IN, OUT_POLARITY_IN;
  logic [9:0] OUT_ENABLE_IN, IO_OUT, IO_OE_OUT, ARRAY_FB_OUT, REG_STATE_OUT, cap_req, drive_req, io_val;
  logic [7:0] VERIFY_DATA_IN, SIG_WR_DATA_IN, SIG_RD_DATA_OUT, VERIFY_DATA_OUT;
  logic [3:0] PRELOAD_SEL_IN;
  logic [2:0] SIG_ADDR_IN;
  int errors, n_compared, k;
  prs_top dut (.CORE_CLK_IN, .RST_N_IN, .LOGIC_IN, .IO_IN, .IO_DRIVEN_IN, .INPUT_OR_SLEEP_PIN_IN,
    .SLEEP_ENABLE_FUSE_IN, .NEXT_STATE_IN, .REG_CAPTURE_IN, .SYNC_RESET_TERM_IN,
    .ASYNC_RESET_TERM_IN, .OUT_POLARITY_IN, .OUT_ENABLE_IN, .PRELOAD_EN_IN, .PRELOAD_SEL_IN,
    .PRELOAD_VALUE_IN, .VERIFY_REQ_IN, .VERIFY_DATA_IN, .SECURE_PROGRAM_IN, .SIG_WR_IN,
    .SIG_ADDR_IN, .SIG_WR_DATA_IN, .SIG_RD_DATA_OUT, .IO_OUT, .IO_OE_OUT, .ARRAY_IN_OUT,
    .ARRAY_FB_OUT, .REG_STATE_OUT, .SYNC_RESET_TERM_OUT, .ASYNC_RESET_TERM_OUT,
    .VERIFY_DATA_OUT, .VERIFY_VALID_OUT, .SECURED_OUT, .CLEAR_DONE_OUT, .SLEEPING_OUT);
  prs_far_side far (.clk_in(CORE_CLK_IN), .rst_n_in(RST_N_IN), .clear_done_in(CLEAR_DONE_OUT),
    .cap_req_in(cap_req), .drive_req_in(drive_req), .io_val_in(io_val),
    .capture_out(REG_CAPTURE_IN), .io_out(IO_IN), .io_driven_out(IO_DRIVEN_IN));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge CORE_CLK_IN);
    #1;
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    CORE_CLK_IN = 1'b0;
    forever #20 CORE_CLK_IN = ~CORE_CLK_IN;
  end
  initial begin
    {errors, n_compared, RST_N_IN, INPUT_OR_SLEEP_PIN_IN, SLEEP_ENABLE_FUSE_IN} = '0;
    {SYNC_RESET_TERM_IN, ASYNC_RESET_TERM_IN, PRELOAD_EN_IN, PRELOAD_VALUE_IN} = 4'h0;
    {VERIFY_REQ_IN, SECURE_PROGRAM_IN, SIG_WR_IN, cap_req, drive_req, io_val} = 33'h0;
    {NEXT_STATE_IN, VERIFY_DATA_IN, SIG_WR_DATA_IN, PRELOAD_SEL_IN, SIG_ADDR_IN} = 33'h0;
    {LOGIC_IN, OUT_POLARITY_IN, OUT_ENABLE_IN} = {12'ha5c, 10'h2a5, 10'h3f0};
    repeat (4) @(posedge CORE_CLK_IN);
    RST_N_IN <= 1'b1;
    for (k = 0; k < 40 && CLEAR_DONE_OUT !== 1'b1; k++) wt(1);
    if (k == 40) begin
      errors++;
      print_verdict();
    end
    chk(REG_STATE_OUT, 10'h000);
    chk(IO_OUT, 10'h2a5);
    chk({SYNC_RESET_TERM_OUT, ASYNC_RESET_TERM_OUT}, 2'h0);
    chk(ARRAY_IN_OUT, 12'ha5c);
    $display("test clear done");
    for (k = 0; k < 11; k++) begin
      @(posedge CORE_CLK_IN);
      {PRELOAD_EN_IN, PRELOAD_SEL_IN, PRELOAD_VALUE_IN} <= {1'b1, k[3:0], k[0] ^ k[1]};
    end
    @(posedge CORE_CLK_IN);
    PRELOAD_EN_IN <= 1'b0;
    wt(2);
    chk(REG_STATE_OUT, 10'h266);
    chk(IO_OUT, 10'h266 ^ 10'h2a5);
    chk(IO_OE_OUT, 10'h3f0);
    @(posedge CORE_CLK_IN);
    INPUT_OR_SLEEP_PIN_IN <= 1'b1;
    wt(2);
    chk(ARRAY_IN_OUT[0], 1'b1);
    @(posedge CORE_CLK_IN);
    {SLEEP_ENABLE_FUSE_IN, cap_req, NEXT_STATE_IN, OUT_POLARITY_IN} <= {1'b1, 10'h00f, 20'h0f000};
    {PRELOAD_EN_IN, PRELOAD_SEL_IN, PRELOAD_VALUE_IN} <= 6'h21;
    wt(4);
    chk({SLEEPING_OUT, REG_STATE_OUT}, {1'b1, 10'h266});
    chk(IO_OUT, 10'h266 ^ 10'h2a5);
    @(posedge CORE_CLK_IN);
    {PRELOAD_EN_IN, INPUT_OR_SLEEP_PIN_IN} <= 2'h0;
    wt(3);
    chk({ARRAY_IN_OUT[0], REG_STATE_OUT, IO_OUT}, {1'b0, 10'h26c, 10'h26c});
    cap_req <= 10'h000;
    $display("test preload and sleep done");
    @(posedge CORE_CLK_IN);
    {drive_req, io_val} <= {10'h3ff, 10'h155};
    wt(3);
    chk(ARRAY_FB_OUT, 10'h155);
    drive_req <= 10'h000;
    wt(4);
    chk(ARRAY_FB_OUT, 10'h155);
    @(posedge CORE_CLK_IN);
    SYNC_RESET_TERM_IN <= 1'b1;
    @(posedge CORE_CLK_IN);
    {SYNC_RESET_TERM_IN, ASYNC_RESET_TERM_IN} <= 2'h1;
    @(posedge CORE_CLK_IN);
    ASYNC_RESET_TERM_IN <= 1'b0;
    wt(4);
    chk(REG_STATE_OUT, 10'h000);
    $display("test keeper and reset terms done");
    for (k = 0; k < 8; k++) begin
      @(posedge CORE_CLK_IN);
      {SIG_WR_IN, SIG_ADDR_IN, SIG_WR_DATA_IN} <= {1'b1, k[2:0], 8'h30 + k[7:0]};
    end
    @(posedge CORE_CLK_IN);
    {SIG_WR_IN, VERIFY_REQ_IN, VERIFY_DATA_IN} <= {2'h1, 8'h5a};
    @(posedge CORE_CLK_IN);
    SECURE_PROGRAM_IN <= 1'b1;
    #1 chk({VERIFY_VALID_OUT, VERIFY_DATA_OUT}, 9'h15a);
    @(posedge CORE_CLK_IN);
    SECURE_PROGRAM_IN <= 1'b0;
    {PRELOAD_EN_IN, PRELOAD_SEL_IN, PRELOAD_VALUE_IN} <= 6'h21;
    wt(3);
    chk({SECURED_OUT, VERIFY_VALID_OUT, REG_STATE_OUT}, {2'h2, 10'h000});
    {PRELOAD_EN_IN, VERIFY_REQ_IN} <= 2'h0;
    for (k = 0; k < 8; k++) begin
      @(posedge CORE_CLK_IN);
      SIG_ADDR_IN <= k[2:0];
      wt(1);
      chk(SIG_RD_DATA_OUT, 8'h30 + k[7:0]);
    end
    $display("test signature and security done");
    print_verdict();
  end
endmodule
`default_nettype wire
